// [core/sdc_pkg.sv]
// Constants, field layout and bus carriers of the stall detect control logic
package sdc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_RTZ_CTL = 3'h0;
  localparam logic [2:0] IDX_MDC_CTL = 3'h1;
  localparam logic [2:0] IDX_SSD_CTL = 3'h2;
  localparam logic [2:0] IDX_FLAGS = 3'h3;
  localparam logic [2:0] IDX_CNT_HI = 3'h4;
  localparam logic [2:0] IDX_CNT_LO = 3'h5;
  localparam logic [2:0] IDX_ACC_HI = 3'h6;
  localparam logic [2:0] IDX_ACC_LO = 3'h7;
  // Return-to-zero control fields
  localparam int unsigned RTZ_ITG_BIT = 7;
  localparam int unsigned RTZ_DRIVE_COIL_ENABLE_BIT = 6;
  localparam int unsigned RTZ_RECIRC_SIDE_SELECT_BIT = 5;
  localparam int unsigned RTZ_POL_BIT = 4;
  localparam int unsigned RTZ_SMS_BIT = 2;
  localparam int unsigned RTZ_STEP_LSB = 0;
  localparam logic [7:0] RTZ_MASK = 8'hF7;
  localparam logic [7:0] RTZ_RST = 8'h00;
  // Modulus counter control fields
  localparam int unsigned MDC_UFIE_BIT = 7;
  localparam int unsigned MDC_RELOAD_BIT = 6;
  localparam int unsigned MDC_RDSEL_BIT = 5;
  localparam int unsigned MDC_PRE_BIT = 4;
  localparam int unsigned MDC_FORCE_BIT = 3;
  localparam int unsigned MDC_EN_BIT = 2;
  localparam int unsigned MDC_OVIE_BIT = 0;
  localparam logic [7:0] MDC_MASK = 8'hF5;
  localparam logic [7:0] MDC_RST = 8'h00;
  // Stall detector control fields
  localparam int unsigned SSD_RETURN_ZERO_ENABLE_BIT = 7;
  localparam logic [7:0] SSD_MASK = 8'hE3;
  localparam logic [7:0] SSD_RST = 8'h00;
  // Flag fields
  localparam int unsigned FLG_UF_BIT = 7;
  localparam int unsigned FLG_OV_BIT = 0;
  // Counter
  localparam logic [15:0] CNT_PRESET = 16'hFFFF;
  localparam logic [15:0] LOAD_RST = 16'h0000;
  localparam int unsigned PRE_DIV_LO = 64;
  localparam int unsigned PRE_DIV_HI = 512;
  localparam logic [8:0] PRE_LIM_LO = 9'(PRE_DIV_LO - 1);
  localparam logic [8:0] PRE_LIM_HI = 9'(PRE_DIV_HI - 1);
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    POLE_EAST = 2'b00,
    POLE_NORTH = 2'b01,
    POLE_WEST = 2'b10,
    POLE_SOUTH = 2'b11
  } sdc_pole_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } sdc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } sdc_axil_rsp_t;
endpackage

// [core/sdc_top.sv]
// Stall detect coil decode and modulus down-counter with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module sdc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire sdc_pkg::sdc_axil_req_t axil_req,
  output sdc_pkg::sdc_axil_rsp_t axil_rsp,
  input wire logic acc_overflow_evt,
  output logic [7:0] bridge_on_a,
  output logic [7:0] bridge_on_b,
  output logic [7:0] switch_close_a,
  output logic [7:0] switch_close_b,
  output logic coil_own_a,
  output logic coil_own_b,
  output logic conv_reset,
  output logic acc_clear,
  output logic underflow_irq,
  output logic overflow_irq
);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [2:0] idx);
    reg_hit = (addr[7:5] == 3'h0) && (addr[4:2] == idx);
  endfunction

  function automatic logic [7:0] bridge_dec(input logic [1:0] step, input logic integrate_select,
                                            input logic drive_coil_enable, input logic recirc_side_select);
    logic [7:0] t;
    t = 8'h00;
    if (drive_coil_enable)
    begin
      unique case (sdc_pkg::sdc_pole_t'(step))
        sdc_pkg::POLE_EAST: t = 8'h09;
        sdc_pkg::POLE_NORTH: t = 8'h90;
        sdc_pkg::POLE_WEST: t = 8'h06;
        sdc_pkg::POLE_SOUTH: t = 8'h60;
      endcase
    end
    if (!integrate_select)
    begin
      if (!step[0])
        t = t | (recirc_side_select ? 8'hA0 : 8'h50);
      else
        t = t | (recirc_side_select ? 8'h0A : 8'h05);
    end
    bridge_dec = t;
  endfunction

  function automatic logic [7:0] switch_dec(input logic [1:0] step, input logic integrate_select,
                                            input logic pol);
    logic swap;
    logic [7:0] s;
    swap = step[1] ^ pol;
    s = 8'h00;
    if (integrate_select)
    begin
      if (!step[0])
        s = swap ? 8'h60 : 8'h90;
      else
        s = swap ? 8'h09 : 8'h06;
    end
    switch_dec = s;
  endfunction

  logic [7:0] rtz_q;
  logic [7:0] mdc_q;
  logic [7:0] ssd_q;
  logic uf_flag_q;
  logic ov_flag_q;
  logic [15:0] load_q;
  logic [15:0] cnt_q;
  logic pre_act_q;
  logic [8:0] presc_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign axil_rsp = '{awready: awready_q, wready: wready_q, bresp: bresp_q, bvalid: bvalid_q,
                      arready: arready_q, rdata: rdata_q, rresp: rresp_q, rvalid: rvalid_q};

  // Bus handshakes and register write strobes
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_mapped;
  logic wr_rtz;
  logic wr_mdc;
  logic wr_ssd;
  logic wr_flg;
  logic wr_cnt;
  logic do_force;
  logic [15:0] wcnt_val;
  logic cnt_en;
  logic reload_md;
  logic tick;
  logic cnt_direct;
  logic uf_set;
  logic [7:0] rd_byte;
  logic [15:0] cnt_view;

  assign aw_hs = axil_req.awvalid & awready_q;
  assign w_hs = axil_req.wvalid & wready_q;
  assign ar_hs = axil_req.arvalid & arready_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_mapped = aw_addr_q[7:5] == 3'h0;
  assign wr_rtz = wr_fire & reg_hit(aw_addr_q, sdc_pkg::IDX_RTZ_CTL) & w_strb_q[0];
  assign wr_mdc = wr_fire & reg_hit(aw_addr_q, sdc_pkg::IDX_MDC_CTL) & w_strb_q[0];
  assign wr_ssd = wr_fire & reg_hit(aw_addr_q, sdc_pkg::IDX_SSD_CTL) & w_strb_q[0];
  assign wr_flg = wr_fire & reg_hit(aw_addr_q, sdc_pkg::IDX_FLAGS) & w_strb_q[0];
  assign wr_cnt = wr_fire & ((reg_hit(aw_addr_q, sdc_pkg::IDX_CNT_HI) & (|w_strb_q[1:0]))
                  | (reg_hit(aw_addr_q, sdc_pkg::IDX_CNT_LO) & w_strb_q[0]));
  assign do_force = wr_mdc & w_data_q[sdc_pkg::MDC_FORCE_BIT];
  assign wcnt_val = reg_hit(aw_addr_q, sdc_pkg::IDX_CNT_HI) ?
                    {(w_strb_q[1] ? w_data_q[15:8] : load_q[15:8]),
                     (w_strb_q[0] ? w_data_q[7:0] : load_q[7:0])} :
                    {load_q[15:8], w_data_q[7:0]};
  assign cnt_en = mdc_q[sdc_pkg::MDC_EN_BIT];
  assign reload_md = mdc_q[sdc_pkg::MDC_RELOAD_BIT];
  assign tick = presc_q == (pre_act_q ? sdc_pkg::PRE_LIM_HI : sdc_pkg::PRE_LIM_LO);
  assign cnt_direct = wr_cnt & ~reload_md;
  assign uf_set = clk_en & cnt_en & tick & (cnt_q == 16'h0001) & ~do_force & ~cnt_direct;
  assign cnt_view = mdc_q[sdc_pkg::MDC_RDSEL_BIT] ? load_q : cnt_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (aw_hs)
      begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= axil_req.awaddr;
      end
      else if (bvalid_q & axil_req.bready)
      begin
        aw_full_q <= 1'b0;
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (w_hs)
      begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= axil_req.wdata;
        w_strb_q <= axil_req.wstrb;
      end
      else if (bvalid_q & axil_req.bready)
      begin
        w_full_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= sdc_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? sdc_pkg::RESP_OKAY : sdc_pkg::RESP_SLVERR;
      end
      else if (axil_req.bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read path; accumulator words read as zero here
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (axil_req.araddr[4:2])
      sdc_pkg::IDX_RTZ_CTL: rd_byte = rtz_q;
      sdc_pkg::IDX_MDC_CTL: rd_byte = mdc_q;
      sdc_pkg::IDX_SSD_CTL: rd_byte = ssd_q;
      sdc_pkg::IDX_FLAGS: rd_byte = {uf_flag_q, 6'h00, ov_flag_q};
      sdc_pkg::IDX_CNT_HI: rd_byte = cnt_view[15:8];
      sdc_pkg::IDX_CNT_LO: rd_byte = cnt_view[7:0];
      sdc_pkg::IDX_ACC_HI: rd_byte = 8'h00;
      sdc_pkg::IDX_ACC_LO: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= sdc_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (ar_hs)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= (axil_req.araddr[7:5] == 3'h0) ? sdc_pkg::RESP_OKAY : sdc_pkg::RESP_SLVERR;
        if (axil_req.araddr[7:5] != 3'h0)
          rdata_q <= 32'h0000_0000;
        else if (reg_hit(axil_req.araddr, sdc_pkg::IDX_CNT_HI))
          rdata_q <= {16'h0000, cnt_view};
        else
          rdata_q <= {24'h00_0000, rd_byte};
      end
      else if (rvalid_q & axil_req.rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Control registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rtz_q <= sdc_pkg::RTZ_RST;
      mdc_q <= sdc_pkg::MDC_RST;
      ssd_q <= sdc_pkg::SSD_RST;
    end
    else if (clk_en)
    begin
      if (wr_rtz)
        rtz_q <= w_data_q[7:0] & sdc_pkg::RTZ_MASK;
      if (wr_mdc)
        mdc_q <= w_data_q[7:0] & sdc_pkg::MDC_MASK;
      if (wr_ssd)
        ssd_q <= w_data_q[7:0] & sdc_pkg::SSD_MASK;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      uf_flag_q <= 1'b0;
      ov_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (uf_set)
        uf_flag_q <= 1'b1;
      else if (wr_flg & w_data_q[sdc_pkg::FLG_UF_BIT])
        uf_flag_q <= 1'b0;
      if (acc_overflow_evt)
        ov_flag_q <= 1'b1;
      else if (wr_flg & w_data_q[sdc_pkg::FLG_OV_BIT])
        ov_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      load_q <= sdc_pkg::LOAD_RST;
    else if (clk_en & wr_cnt)
      load_q <= wcnt_val;
  end

  // Modulus counter and prescaler
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= sdc_pkg::CNT_PRESET;
      presc_q <= 9'h000;
      pre_act_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!cnt_en)
      begin
        cnt_q <= sdc_pkg::CNT_PRESET;
        presc_q <= 9'h000;
      end
      else if (do_force)
      begin
        cnt_q <= load_q;
        presc_q <= 9'h000;
        pre_act_q <= mdc_q[sdc_pkg::MDC_PRE_BIT];
      end
      else if (cnt_direct)
      begin
        cnt_q <= wcnt_val;
        presc_q <= 9'h000;
        pre_act_q <= mdc_q[sdc_pkg::MDC_PRE_BIT];
      end
      else if (tick)
      begin
        presc_q <= 9'h000;
        if (cnt_q != 16'h0000)
          cnt_q <= cnt_q - 16'h0001;
        else if (reload_md)
        begin
          cnt_q <= load_q;
          pre_act_q <= mdc_q[sdc_pkg::MDC_PRE_BIT];
        end
      end
      else
        presc_q <= presc_q + 9'h001;
    end
  end

  // Coil drive, converter routing and interrupt outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bridge_on_a <= 8'h00;
      bridge_on_b <= 8'h00;
      switch_close_a <= 8'h00;
      switch_close_b <= 8'h00;
      coil_own_a <= 1'b0;
      coil_own_b <= 1'b0;
      conv_reset <= 1'b1;
      acc_clear <= 1'b1;
    end
    else if (clk_en)
    begin
      logic return_zero_enable;
      logic sel_b;
      logic [7:0] br;
      logic [7:0] sw;
      return_zero_enable = ssd_q[sdc_pkg::SSD_RETURN_ZERO_ENABLE_BIT];
      sel_b = rtz_q[sdc_pkg::RTZ_SMS_BIT];
      br = return_zero_enable ? bridge_dec(rtz_q[sdc_pkg::RTZ_STEP_LSB +: 2], rtz_q[sdc_pkg::RTZ_ITG_BIT],
                             rtz_q[sdc_pkg::RTZ_DRIVE_COIL_ENABLE_BIT], rtz_q[sdc_pkg::RTZ_RECIRC_SIDE_SELECT_BIT])
                 : 8'h00;
      sw = switch_dec(rtz_q[sdc_pkg::RTZ_STEP_LSB +: 2], rtz_q[sdc_pkg::RTZ_ITG_BIT],
                      rtz_q[sdc_pkg::RTZ_POL_BIT]);
      bridge_on_a <= sel_b ? 8'h00 : br;
      bridge_on_b <= sel_b ? br : 8'h00;
      switch_close_a <= sel_b ? 8'h00 : sw;
      switch_close_b <= sel_b ? sw : 8'h00;
      coil_own_a <= return_zero_enable & ~sel_b;
      coil_own_b <= return_zero_enable & sel_b;
      conv_reset <= ~rtz_q[sdc_pkg::RTZ_ITG_BIT];
      acc_clear <= ~rtz_q[sdc_pkg::RTZ_ITG_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      underflow_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      underflow_irq <= uf_flag_q & mdc_q[sdc_pkg::MDC_UFIE_BIT];
      overflow_irq <= ov_flag_q & mdc_q[sdc_pkg::MDC_OVIE_BIT];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_free_step;
    clk_en && cnt_en && !do_force && !cnt_direct;
  endsequence

  a_uf_irq_gate: assert property (clk_en |=> underflow_irq == $past(uf_flag_q &
    mdc_q[sdc_pkg::MDC_UFIE_BIT])) else $error("underflow irq mismatch");
  a_ov_irq_gate: assert property (clk_en |=> overflow_irq == $past(ov_flag_q &
    mdc_q[sdc_pkg::MDC_OVIE_BIT])) else $error("overflow irq mismatch");
  a_cnt_preset: assert property (clk_en && !cnt_en |=> cnt_q == 16'hFFFF)
    else $error("disabled counter not preset");
  a_halt_zero: assert property (s_free_step and (!reload_md && cnt_q == 16'h0000)
    |=> cnt_q == 16'h0000) else $error("counter left zero");
  a_reload_zero: assert property (s_free_step and (reload_md && tick && cnt_q == 16'h0000)
    |=> cnt_q == $past(load_q)) else $error("reload missing");
  a_dec_one: assert property (s_free_step and (tick && cnt_q != 16'h0000)
    |=> cnt_q == $past(cnt_q) - 16'h0001) else $error("bad decrement");
  a_hold_between: assert property (s_free_step and !tick |=> $stable(cnt_q))
    else $error("count moved between ticks");
  a_force_load: assert property (clk_en && cnt_en && do_force |=> cnt_q == $past(load_q))
    else $error("force load failed");
  a_zero_no_flag: assert property (clk_en && cnt_en && cnt_direct && wcnt_val == 16'h0000
    |=> !uf_set [*3]) else $error("zero write set flag");
  a_uf_flag_set: assert property (uf_set |=> uf_flag_q)
    else $error("underflow flag not set");
  a_rtz_off: assert property (clk_en && !ssd_q[sdc_pkg::SSD_RETURN_ZERO_ENABLE_BIT]
    |=> bridge_on_a == 8'h00 && bridge_on_b == 8'h00) else $error("coils driven");
  a_switch_open: assert property (clk_en && !rtz_q[sdc_pkg::RTZ_ITG_BIT]
    |=> switch_close_a == 8'h00 && switch_close_b == 8'h00 && conv_reset)
    else $error("switch closed in blanking");
  a_idle_int: assert property (clk_en && rtz_q[sdc_pkg::RTZ_ITG_BIT] &&
    !rtz_q[sdc_pkg::RTZ_DRIVE_COIL_ENABLE_BIT] |=> bridge_on_a == 8'h00 && bridge_on_b == 8'h00)
    else $error("bridge on while integrating undriven");
  a_motor_b: assert property (clk_en && rtz_q[sdc_pkg::RTZ_SMS_BIT]
    |=> bridge_on_a == 8'h00 && switch_close_a == 8'h00) else $error("motor A active");

endmodule
`default_nettype wire

// [tb/sdc_coil_model.sv]
// Coil current model driven by the half-bridge transistor states
`timescale 1ns/100ps
`default_nettype none
module sdc_coil_model (
  input wire logic [7:0] bridge_on,
  output logic [1:0] cos_cur,
  output logic [1:0] sin_cur
);
  // Current sign per coil: 1 plus, 3 minus, 0 none
  always_comb
  begin
    cos_cur = 2'h0;
    sin_cur = 2'h0;
    if (bridge_on[0] && bridge_on[3]) cos_cur = 2'h1;
    if (bridge_on[1] && bridge_on[2]) cos_cur = 2'h3;
    if (bridge_on[4] && bridge_on[7]) sin_cur = 2'h1;
    if (bridge_on[5] && bridge_on[6]) sin_cur = 2'h3;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the stall detect coil decode and modulus counter
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] A_RTZ = {3'h0, sdc_pkg::IDX_RTZ_CTL, 2'h0};
  localparam logic [7:0] A_MDC = {3'h0, sdc_pkg::IDX_MDC_CTL, 2'h0};
  localparam logic [7:0] A_SSD = {3'h0, sdc_pkg::IDX_SSD_CTL, 2'h0};
  localparam logic [7:0] A_FLG = {3'h0, sdc_pkg::IDX_FLAGS, 2'h0};
  localparam logic [7:0] A_CNT = {3'h0, sdc_pkg::IDX_CNT_HI, 2'h0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic ovf_evt = 1'b0;
  sdc_pkg::sdc_axil_req_t req = '0;
  sdc_pkg::sdc_axil_rsp_t rsp;
  logic [7:0] br_a, br_b, sw_a, sw_b, rtz_m, ssd_m, sr;
  logic own_a, own_b, cres, aclr, uf_irq, ov_irq, oa, ob;
  logic [1:0] ca, sa, cb, sb, rs;
  logic [3:0] ec;
  logic [31:0] rd, c1, c2;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'hb5aa;
  int cyc = 0;
  int dv;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  sdc_top dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .axil_req(req), .axil_rsp(rsp),
    .acc_overflow_evt(ovf_evt), .bridge_on_a(br_a), .bridge_on_b(br_b),
    .switch_close_a(sw_a), .switch_close_b(sw_b), .coil_own_a(own_a), .coil_own_b(own_b),
    .conv_reset(cres), .acc_clear(aclr), .underflow_irq(uf_irq), .overflow_irq(ov_irq)
  );
  sdc_coil_model coil_a_u (.bridge_on(br_a), .cos_cur(ca), .sin_cur(sa));
  sdc_coil_model coil_b_u (.bridge_on(br_b), .cos_cur(cb), .sin_cur(sb));

  function automatic logic [7:0] exp_br(input logic [7:0] r);
    logic [31:0] t;
    logic [7:0] v;
    t = 32'h6006_9009 >> (8 * r[1:0]);
    v = r[6] ? t[7:0] : 8'h00;
    if (!r[7]) v = v | (r[0] ? (r[5] ? 8'h0A : 8'h05) : (r[5] ? 8'hA0 : 8'h50));
    return v;
  endfunction

  function automatic logic [7:0] exp_sw(input logic [7:0] r);
    if (!r[7]) return 8'h00;
    if (r[0]) return (r[1] ^ r[4]) ? 8'h09 : 8'h06;
    return (r[1] ^ r[4]) ? 8'h60 : 8'h90;
  endfunction

  task automatic fail(input string m);
    bad_count++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("value %h expected %h", g, e));
  endtask

  task automatic chk_out(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("pins %b expected %b", g, e));
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.awaddr <= a;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid && n < 40);
    r = rsp.bresp;
    if (n >= 40) fail("write hang");
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid && n < 40);
    d = rsp.rdata;
    r = rsp.rresp;
    if (n >= 40) fail("read hang");
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk_reg({30'h0, r}, {30'h0, sdc_pkg::RESP_OKAY});
    chk_reg(d, e);
  endtask

  // Count reads started sp cycles apart; returns the drop
  task automatic drop(input int sp);
    int t0;
    t0 = cyc;
    rdr(A_CNT, c1, rs);
    while (cyc < t0 + sp) @(posedge sys_clk);
    rdr(A_CNT, c2, rs);
    dv = int'(c1) - int'(c2);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial
  begin
    wt(30000);
    fail("watchdog");
    close_out();
  end

  initial
  begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    wt(10);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rchk(A_MDC, 32'h0);
    rchk(A_CNT, 32'h0000_FFFF);
    rchk(A_FLG, 32'h0);
    wr(8'h20, 16'h00FF, rs);
    chk_reg({30'h0, rs}, {30'h0, sdc_pkg::RESP_SLVERR});
    rdr(8'hE0, rd, rs);
    chk_reg({rd, 6'h0, rs}, {32'h0, 6'h0, sdc_pkg::RESP_SLVERR});
    for (int i = 0; i < 64; i++)
    begin
      sr = 8'($random(seed));
      rtz_m = {i[5:2], sr[1:0], i[1:0]};
      ssd_m = 8'($random(seed));
      wr(A_SSD, {8'h00, ssd_m}, rs);
      wr(A_RTZ, {8'h00, rtz_m}, rs);
      rchk(A_RTZ, {24'h0, rtz_m & 8'hF7});
      rchk(A_SSD, {24'h0, ssd_m & 8'hE3});
      wt(2);
      oa = ssd_m[7] && !rtz_m[2];
      ob = ssd_m[7] && rtz_m[2];
      ec = rtz_m[6] ? 4'(16'h3C14 >> (4 * rtz_m[1:0])) : 4'h0;
      chk_out(br_a, oa ? exp_br(rtz_m) : 8'h00);
      chk_out(br_b, ob ? exp_br(rtz_m) : 8'h00);
      chk_out(sw_a, rtz_m[2] ? 8'h00 : exp_sw(rtz_m));
      chk_out(sw_b, rtz_m[2] ? exp_sw(rtz_m) : 8'h00);
      chk_out({4'h0, own_a, own_b, cres, aclr}, {4'h0, oa, ob, ~rtz_m[7], ~rtz_m[7]});
      chk_out({ca, sa, cb, sb}, {oa ? ec : 4'h0, ob ? ec : 4'h0});
    end
    wr(A_MDC, 16'h0004, rs);
    wr(A_CNT, 16'd100, rs);
    rchk(A_MDC, 32'h0000_0004);
    drop(64);
    chk_reg(32'(dv), 32'h1);
    wr(A_MDC, 16'h0024, rs);
    rchk(A_CNT, 32'd100);
    wr(A_MDC, 16'h0014, rs);
    drop(64);
    chk_reg(32'(dv), 32'h1);
    wr(A_MDC, 16'h001C, rs);
    rchk(A_MDC, 32'h0000_0014);
    rchk(A_CNT, 32'd100);
    drop(512);
    chk_reg(32'(dv), 32'h1);
    wr(A_MDC, 16'h0004, rs);
    wr(A_CNT, 16'd3, rs);
    rchk(A_FLG, 32'h0);
    rdr(A_CNT, c1, rs);
    clk_en <= 1'b0;
    wt(200);
    clk_en <= 1'b1;
    rdr(A_CNT, c2, rs);
    dv = int'(c1) - int'(c2);
    chk_reg(32'(dv), 32'h0);
    wt(220);
    rchk(A_CNT, 32'h0);
    rchk(A_FLG, 32'h0000_0080);
    chk_out({7'h0, uf_irq}, 8'h00);
    wr(A_FLG, 16'h0000, rs);
    rchk(A_FLG, 32'h0000_0080);
    wr(A_MDC, 16'h0084, rs);
    wt(3);
    chk_out({7'h0, uf_irq}, 8'h01);
    wt(100);
    rchk(A_CNT, 32'h0);
    wr(A_FLG, 16'h0080, rs);
    rchk(A_FLG, 32'h0);
    wt(3);
    chk_out({7'h0, uf_irq}, 8'h00);
    wr(A_CNT, 16'h0000, rs);
    wt(200);
    rchk(A_CNT, 32'h0);
    rchk(A_FLG, 32'h0);
    wr(A_MDC, 16'h0000, rs);
    rchk(A_CNT, 32'h0000_FFFF);
    wr(A_MDC, 16'h0044, rs);
    wr(A_CNT, 16'd2, rs);
    wr(A_MDC, 16'h004C, rs);
    wt(300);
    rchk(A_FLG, 32'h0000_0080);
    drop(64);
    chk_reg({31'h0, dv != 0}, 32'h1);
    wr(A_MDC, 16'h0064, rs);
    rchk(A_CNT, 32'd2);
    wr(A_MDC, 16'h0000, rs);
    wr(A_FLG, 16'h0081, rs);
    @(posedge sys_clk) ovf_evt <= 1'b1;
    @(posedge sys_clk) ovf_evt <= 1'b0;
    wt(3);
    chk_out({7'h0, ov_irq}, 8'h00);
    rchk(A_FLG, 32'h0000_0001);
    wr(A_MDC, 16'h0001, rs);
    wt(3);
    chk_out({7'h0, ov_irq}, 8'h01);
    wr(A_FLG, 16'h0001, rs);
    wt(3);
    chk_out({7'h0, ov_irq}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
